// >>> dcas_params.svh
// Constants for the DRAM CPU access sequencer: input indices, reset levels, sync depth
`ifndef DCAS_PARAMS_SVH
`define DCAS_PARAMS_SVH

// Number of pins sampled from the CPU bus side
`define DCAS_NUM_IN       8
// Bit positions of the sampled pins in the raw input vector
`define DCAS_IX_CPU_CLK   0
`define DCAS_IX_AS_B      1
`define DCAS_IX_CS_B      2
`define DCAS_IX_RD_WR     3
`define DCAS_IX_RFRQ      4
`define DCAS_IX_BYTE_B    5
`define DCAS_IX_HRD_B     6
`define DCAS_IX_WAIT_B    7
// Reset level of the filtered pins: every pin idle high
`define DCAS_IN_RESET     8'hFF
// Synchroniser stages an outside pin passes before the agreement filter
`define DCAS_SYNC_STAGES  3
// Level of an active-low output pin while inactive
`define DCAS_PIN_IDLE     1'b1
// Level of the drive enable of the acknowledge pin after reset
`define DCAS_OE_RESET     1'b0

`endif

// >>> dcas_pkg.sv
// Types and pin decoding shared by the DRAM CPU access sequencer modules
`include "dcas_params.svh"

package dcas_pkg;

   // Bus conditions in active-high form
   typedef struct packed {
      logic addr_strobe;
      logic chip_select;
      logic read_dir;
      logic refresh_req;
      logic byte_strobe;
      logic hidden_off;
      logic wait_req;
      logic clk_low;
   } dcas_bus_s;

   typedef logic [`DCAS_NUM_IN-1:0] dcas_pins_t;

   // Turns the filtered pin levels into asserted conditions
   function automatic dcas_bus_s dcas_decode(input dcas_pins_t pins);
      dcas_bus_s b;
      b.addr_strobe = ~pins[`DCAS_IX_AS_B];
      b.chip_select = ~pins[`DCAS_IX_CS_B];
      b.read_dir    = pins[`DCAS_IX_RD_WR];
      b.refresh_req = ~pins[`DCAS_IX_RFRQ];
      b.byte_strobe = ~pins[`DCAS_IX_BYTE_B];
      b.hidden_off  = ~pins[`DCAS_IX_HRD_B];
      b.wait_req    = ~pins[`DCAS_IX_WAIT_B];
      b.clk_low     = ~pins[`DCAS_IX_CPU_CLK];
      return b;
   endfunction : dcas_decode

endpackage : dcas_pkg

// >>> dcas_if.sv
// Carrier of filtered bus pins and the CPU clock edge between sequencer modules
`timescale 1ns/10ps
`default_nettype none

interface dcas_if;
   dcas_pkg::dcas_pins_t pins_f;
   logic                 cpu_rise;

   modport src (output pins_f, output cpu_rise);
   modport dst (input pins_f, input cpu_rise);
endinterface : dcas_if

`default_nettype wire

// >>> dcas_sync.sv
// Three-stage pin synchroniser with agreement filter and CPU clock edge detect
`timescale 1ns/10ps
`default_nettype none
`include "dcas_params.svh"

module dcas_sync #(
   parameter int WIDTH = `DCAS_NUM_IN
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] pins_raw,
   dcas_if.src                   sync_if
);
   import dcas_pkg::*;

   localparam logic [WIDTH-1:0] RST_LVL = WIDTH'(`DCAS_IN_RESET);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] filt_q;
   logic             clk_prev_q;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_q <= RST_LVL;
         s2_q <= RST_LVL;
         s3_q <= RST_LVL;
      end else begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change is taken once the second and third stages agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         filt_q <= RST_LVL;
      end else begin
         filt_q <= (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
      end
   end

   // Previous filtered CPU clock level for edge detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clk_prev_q <= RST_LVL[`DCAS_IX_CPU_CLK];
      end else begin
         clk_prev_q <= filt_q[`DCAS_IX_CPU_CLK];
      end
   end

   // Filtered levels and a one-cycle pulse at each CPU clock rise
   assign sync_if.pins_f   = filt_q;
   assign sync_if.cpu_rise = filt_q[`DCAS_IX_CPU_CLK] & ~clk_prev_q;

endmodule : dcas_sync

`default_nettype wire

// >>> dcas_sequencer.sv
// DRAM CPU access sequencer: strobe request, acknowledge, refresh and delay chain
`timescale 1ns/10ps
`default_nettype none
`include "dcas_params.svh"

// Operation
// R1: Read cycles start the row strobe request at the start of bus state S3.
// R2: System gives chip select 34 ns before row strobe, unless hidden refresh is off.
// R3: Write cycles start the row strobe later than reads, giving shortest pulses; the code starts writes with the same term as reads, in the same low phase.
// R4: Read wait state stretches access and strobe widths; write wait stretches precharge.
// R5: Hidden refresh strobe: unselected, address strobe, stage one, no mode/done/flag/disable.
// R6: Selected strobe in low clock phase with stage three, outside mode and done.
// R7: Cycle done ends on clock rise after low phase; held while address strobe stays.
// R8: Cycle done during long foreign accesses: unselected, strobe, stages idle, no mode.
// R9: Access-during-refresh set by mode with address strobe; held with stage three.
// R10: Acknowledge driven only when selected; wait input adds stage one; held through READ_MODIFY_WRITE.
// R11: Forced refresh mode set on refresh request when bus idle.
// R12: Forced refresh mode also set during long foreign accesses with cycle done.
// R13: Forced refresh in foreign long cycle sets stage three, blocking stage one.
// R14: Test-and-set restarts stage one on selected write with cycle done, all idle.
// R15: All control outputs are active low on the pins; the acknowledge drive enable output is active high.
// R16: System drives wait input low for exactly one wait state, maybe from direction.
// R17: Mode output pulls controller mode select low for automatic forced refresh.
// R18: Stage two follows stage one while three idle; three follows two or idle strobe.
// R19: Mode holds until stages two and three set; stage one set during refresh.
// R20: Asserted wait stretches stage one by one clock in a selected access.
module dcas_sequencer (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic cpu_clk,
   input  wire logic cpu_addr_strobe_b,
   input  wire logic chip_select_b,
   input  wire logic read_not_write,
   input  wire logic refresh_request_line,
   input  wire logic any_byte_strobe_b,
   input  wire logic hidden_refresh_disable_b,
   input  wire logic wait_req_b,
   output var  logic row_strobe_request_b,
   output var  logic cycle_done_b,
   output var  logic access_during_refresh_b,
   output var  logic transfer_acknowledge_b,
   output var  logic transfer_acknowledge_oe,
   output var  logic controller_mode_select_b,
   output var  logic delay_stage_one_b,
   output var  logic delay_stage_two_b,
   output var  logic delay_stage_three_b
);
   import dcas_pkg::*;

   dcas_if    link ();
   dcas_bus_s bus;
   dcas_pins_t pins_raw;

   // Asserted views of the output flops, used as feedback
   logic row_strobe_request;
   logic cyc;
   logic incy;
   logic transfer_acknowledge;
   logic mode;
   logic d1;
   logic d2;
   logic d3;

   // Next values
   logic row_strobe_request_d;
   logic cyc_d;
   logic incy_d;
   logic transfer_acknowledge_d;
   logic mode_d;
   logic d1_d;
   logic d2_d;
   logic d3_d;
   logic frc_long;
   logic ras_start;
   logic ras_hold;
   logic bus_idle;
   logic stages_idle;

   // Output flops, held at pin level (low is active, except the acknowledge drive enable)
   logic row_strobe_request_b_q;
   logic cyc_b_q;
   logic incy_b_q;
   logic transfer_acknowledge_b_q;
   logic transfer_acknowledge_oe_q;
   logic mode_b_q;
   logic d1_b_q;
   logic d2_b_q;
   logic d3_b_q;

   // Gather the outside pins for the synchroniser
   always_comb begin
      pins_raw                    = '0;
      pins_raw[`DCAS_IX_CPU_CLK] = cpu_clk;
      pins_raw[`DCAS_IX_AS_B]    = cpu_addr_strobe_b;
      pins_raw[`DCAS_IX_CS_B]    = chip_select_b;
      pins_raw[`DCAS_IX_RD_WR]   = read_not_write;
      pins_raw[`DCAS_IX_RFRQ]    = refresh_request_line;
      pins_raw[`DCAS_IX_BYTE_B]  = any_byte_strobe_b;
      pins_raw[`DCAS_IX_HRD_B]   = hidden_refresh_disable_b;
      pins_raw[`DCAS_IX_WAIT_B]  = wait_req_b;
   end

   dcas_sync #(
      .WIDTH (`DCAS_NUM_IN)
   ) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .pins_raw (pins_raw),
      .sync_if  (link.src)
   );

   // Filtered pins in active-high form
   assign bus = dcas_decode(link.pins_f);

   // Feedback from the pin-level flops
   assign row_strobe_request = ~row_strobe_request_b_q;
   assign cyc   = ~cyc_b_q;
   assign incy  = ~incy_b_q;
   assign transfer_acknowledge = ~transfer_acknowledge_b_q;
   assign mode  = ~mode_b_q;
   assign d1    = ~d1_b_q;
   assign d2    = ~d2_b_q;
   assign d3    = ~d3_b_q;

   // Forced refresh start inside another device's long cycle
   assign frc_long = ~bus.chip_select & bus.refresh_req & bus.addr_strobe & cyc
                   & ~d1 & ~d2 & ~row_strobe_request;

   // No bus activity: strobe idle, no cycle pending, no row strobe
   assign bus_idle = ~bus.addr_strobe & ~cyc & ~row_strobe_request;

   // All three delay stages at rest
   assign stages_idle = ~d1 & ~d2 & ~d3;

   // Row strobe start terms; a selected start waits for stage three in the low phase,
   // which places read starts at S3
   always_comb begin
      ras_start = (bus.chip_select & ~incy & bus.addr_strobe & ~mode & d3 & ~cyc
                   & bus.clk_low)                                      // R1 R3 R6
                | (~bus.chip_select & ~incy & bus.addr_strobe & ~mode & d1 & ~cyc
                   & ~bus.hidden_off)                                  // R5
                | (bus.chip_select & incy & bus.addr_strobe & ~mode & d3 & ~cyc
                   & bus.clk_low);                                     // R6
   end

   // Row strobe hold terms keep the request through the access
   always_comb begin
      ras_hold = (bus.chip_select & row_strobe_request & ~mode & bus.addr_strobe)
               | (row_strobe_request & ~mode & d1);                                 // R4
   end

   // Row strobe request next value
   always_comb begin
      row_strobe_request_d = ras_start | ras_hold;
   end

   // Cycle done: start after stages one and two, hold with strobe, end at clock rise
   always_comb begin
      cyc_d = (~mode & d1 & d2 & ~d3)
            | (cyc & bus.addr_strobe)                                  // R7
            | (~mode & cyc & bus.clk_low)                              // R7
            | (~bus.chip_select & bus.addr_strobe & ~mode & stages_idle);     // R8
   end

   // Access requested during a forced refresh
   always_comb begin
      incy_d = (mode & bus.addr_strobe)                                // R9
             | (incy & d3 & bus.addr_strobe);                          // R9
   end

   // Acknowledge terms; zero or one wait state, continued to cycle end
   always_comb begin
      transfer_acknowledge_d = bus.chip_select & (                                    // R10
                  (bus.addr_strobe & ~bus.wait_req & ~bus.read_dir & ~mode & bus.clk_low)
                | (bus.addr_strobe & bus.wait_req & ~bus.read_dir & ~mode & d1
                   & bus.clk_low)                                      // R4 R16
                | (bus.byte_strobe & ~bus.wait_req & bus.read_dir & ~mode & bus.clk_low)
                | (bus.byte_strobe & bus.wait_req & bus.read_dir & ~mode & d1
                   & bus.clk_low)                                      // R4 R16
                | (transfer_acknowledge & d1 & ~mode)
                | (transfer_acknowledge & bus.addr_strobe & row_strobe_request & ~mode & ~cyc)
                | (transfer_acknowledge & bus.addr_strobe & ~bus.read_dir & ~mode));  // R10
   end

   // Forced refresh mode; set when idle or in long foreign cycles, held by stages
   always_comb begin
      mode_d = (bus.refresh_req & bus_idle)                            // R11
             | frc_long                                                // R12
             | (mode & ~d2)                                            // R19
             | (mode & ~d3);                                           // R19
   end

   // Stage one: started by stage three, refresh or test-and-set, stretched by wait
   always_comb begin
      d1_d = (mode & ~d3)                                              // R19
           | (~incy & bus.addr_strobe & ~cyc & ~mode & ~d2 & d3)
           | (bus.chip_select & incy & bus.addr_strobe & ~cyc & ~mode & ~d2 & d3)
           | (~mode & d1 & ~d2)
           | (bus.chip_select & bus.wait_req & bus.addr_strobe & ~mode & d1 & d2
              & ~d3)                                                   // R20
           | (bus.chip_select & bus.addr_strobe & ~bus.read_dir & cyc & ~mode
              & stages_idle);                                          // R14
   end

   // Stage two follows stage one while stage three rests
   always_comb begin
      d2_d = d1 & ~d3;                                                 // R18
   end

   // Stage three follows stage two, rests set, and blocks stage one at a long refresh
   always_comb begin
      d3_d = d2                                                        // R18
           | (~bus.addr_strobe & ~mode)                                // R18
           | (frc_long & ~mode);                                       // R13
   end

   // Row strobe request pin, re-evaluated on every system clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         row_strobe_request_b_q <= `DCAS_PIN_IDLE;
      end else begin
         row_strobe_request_b_q <= ~row_strobe_request_d;                                        // R15
      end
   end

   // Cycle done pin, re-evaluated on every system clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cyc_b_q <= `DCAS_PIN_IDLE;
      end else begin
         cyc_b_q <= ~cyc_d;                                            // R15
      end
   end

   // Access-during-refresh pin, re-evaluated on every system clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         incy_b_q <= `DCAS_PIN_IDLE;
      end else begin
         incy_b_q <= ~incy_d;                                          // R15
      end
   end

   // Acknowledge pin level
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         transfer_acknowledge_b_q <= `DCAS_PIN_IDLE;
      end else begin
         transfer_acknowledge_b_q <= ~transfer_acknowledge_d;                                        // R15
      end
   end

   // Acknowledge pin is driven only while the device is selected
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         transfer_acknowledge_oe_q <= `DCAS_OE_RESET;
      end else begin
         transfer_acknowledge_oe_q <= bus.chip_select;                                // R10
      end
   end

   // Forced refresh mode steps only on a CPU clock rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_b_q <= `DCAS_PIN_IDLE;
      end else if (link.cpu_rise) begin
         mode_b_q <= ~mode_d;                                          // R17
      end
   end

   // Stage one steps only on a CPU clock rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         d1_b_q <= `DCAS_PIN_IDLE;
      end else if (link.cpu_rise) begin
         d1_b_q <= ~d1_d;
      end
   end

   // Stage two steps only on a CPU clock rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         d2_b_q <= `DCAS_PIN_IDLE;
      end else if (link.cpu_rise) begin
         d2_b_q <= ~d2_d;
      end
   end

   // Stage three steps only on a CPU clock rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         d3_b_q <= `DCAS_PIN_IDLE;
      end else if (link.cpu_rise) begin
         d3_b_q <= ~d3_d;
      end
   end

   // Pins straight from the flops
   assign row_strobe_request_b     = row_strobe_request_b_q;
   assign cycle_done_b             = cyc_b_q;
   assign access_during_refresh_b  = incy_b_q;
   assign transfer_acknowledge_b   = transfer_acknowledge_b_q;
   assign transfer_acknowledge_oe  = transfer_acknowledge_oe_q;
   assign controller_mode_select_b = mode_b_q;
   assign delay_stage_one_b        = d1_b_q;
   assign delay_stage_two_b        = d2_b_q;
   assign delay_stage_three_b      = d3_b_q;

endmodule : dcas_sequencer

`default_nettype wire

// >>> dcas_sequencer_monitor.sv
// Assertion checker for the sequencer pins
`timescale 1ns/10ps
`default_nettype none

module dcas_sequencer_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chip_select_b,
   input wire logic cpu_addr_strobe_b,
   input wire logic row_strobe_request_b,
   input wire logic cycle_done_b,
   input wire logic access_during_refresh_b,
   input wire logic transfer_acknowledge_b,
   input wire logic transfer_acknowledge_oe,
   input wire logic controller_mode_select_b,
   input wire logic delay_stage_one_b,
   input wire logic delay_stage_two_b,
   input wire logic delay_stage_three_b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Long idle spans and settled refresh mode
   sequence s_cs_idle;
      chip_select_b [*8];
   endsequence
   sequence s_mode_on;
      !controller_mode_select_b [*2];
   endsequence

   chk_ack_released: assert property (s_cs_idle |-> !transfer_acknowledge_oe)
      else $error("acknowledge driven while unselected");
   chk_ack_driven: assert property ($fell(chip_select_b) |-> ##[1:8] transfer_acknowledge_oe)
      else $error("acknowledge not driven after select");
   chk_ack_no_mode: assert property (s_mode_on |-> transfer_acknowledge_b)
      else $error("acknowledge during forced refresh");
   chk_ras_no_mode: assert property (s_mode_on |-> row_strobe_request_b)
      else $error("row strobe during forced refresh");
   chk_flag_strobe: assert property (cpu_addr_strobe_b [*8] |-> access_during_refresh_b)
      else $error("refresh flag without address strobe");
   chk_mode_hold: assert property (!controller_mode_select_b
      && (delay_stage_two_b || delay_stage_three_b) |=> !controller_mode_select_b)
      else $error("refresh mode left early");
   chk_stage_two: assert property ($fell(delay_stage_two_b)
      |-> $past(!delay_stage_one_b && delay_stage_three_b))
      else $error("stage two set without stage one");
   chk_stage_one_start: assert property ($fell(delay_stage_one_b)
      |-> $past(!delay_stage_three_b || !controller_mode_select_b || !cycle_done_b)
      || $past(!cycle_done_b, 2))
      else $error("stage one started without cause");
endmodule : dcas_sequencer_monitor

bind dcas_sequencer dcas_sequencer_monitor u_monitor (.clk, .rst_b, .chip_select_b,
   .cpu_addr_strobe_b, .row_strobe_request_b, .cycle_done_b, .access_during_refresh_b,
   .transfer_acknowledge_b, .transfer_acknowledge_oe, .controller_mode_select_b,
   .delay_stage_one_b, .delay_stage_two_b, .delay_stage_three_b);

`default_nettype wire

// >>> dcas_cpu_model.sv
// Behavioural CPU bus master and refresh source
`timescale 1ns/10ps
`default_nettype none

module dcas_cpu_model (
   input  wire logic clk,
   output var  logic cpu_clk,
   output var  logic as_b,
   output var  logic cs_b,
   output var  logic rnw,
   output var  logic rfrq_b,
   output var  logic byte_b,
   output var  logic wait_b,
   input  wire logic ack_w,
   input  wire logic ras_b,
   input  wire logic done_b,
   input  wire logic flag_b,
   input  wire logic mode_b
);
   int ph = 0;

   // Idle bus at time zero
   initial {cpu_clk, as_b, cs_b, rnw, rfrq_b, byte_b, wait_b} = 7'h7F;

   // Free-running CPU clock, ten system clocks a phase
   always @(posedge clk) begin
      ph <= (ph == 9) ? 0 : ph + 1;
      cpu_clk <= (ph == 9) ? ~cpu_clk : cpu_clk;
   end

   // One bus cycle from a CPU clock rise; selected cycles end 40 clocks after acknowledge,
   // long enough for stage two to set and cycle done to show while address strobe stands
   task automatic cycle(input logic sel, input logic rd, input logic wt, input int hold,
                        output int lat, output logic [2:0] seen);
      lat = -1;
      seen = 3'h0;
      @(posedge cpu_clk);
      cs_b   <= ~sel;
      rnw    <= rd;
      wait_b <= ~wt;
      repeat (4) @(posedge clk);
      as_b   <= 1'b0;
      byte_b <= 1'b0;
      for (int n = 0; n < hold; n++) begin
         @(posedge clk);
         #1;
         seen = seen | {ras_b === 1'b0, done_b === 1'b0, flag_b === 1'b0};
         if (ack_w === 1'b0 && lat < 0)
            lat = n;
         if (lat >= 0 && n == lat + 40)
            break;
      end
      @(posedge clk);
      {as_b, byte_b, cs_b, wait_b} <= 4'hF;
      repeat (40) @(posedge clk);
   endtask : cycle

   // Refresh request held until refresh mode shows or 200 clocks pass
   task automatic force_refresh(output logic ok);
      ok = 1'b0;
      @(posedge clk);
      rfrq_b <= 1'b0;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clk);
         #1;
         ok = (mode_b === 1'b0);
      end
      @(posedge clk);
      rfrq_b <= 1'b1;
   endtask : force_refresh
endmodule : dcas_cpu_model

`default_nettype wire

// >>> dcas_sequencer_test.sv
// Self-checking bench for the DRAM CPU access sequencer
`timescale 1ns/10ps
`default_nettype none

module dcas_sequencer_test;
   logic       clk;
   logic       rst_b;
   logic       hrd_b;
   logic [2:0] seen;
   logic       ok;
   int         mismatches = 0;
   int         compares = 0;
   int         lat_n;
   int         lat;
   wire        cpu_clk, as_b, cs_b, rnw, rfrq_b, byte_b, wait_b, ack_w;
   wire        ras_b, done_b, flag_b, ack_b, ack_oe, mode_b, s1_b, s2_b, s3_b;

   // Pulled-up acknowledge line, released while not driven
   assign ack_w = ack_oe ? ack_b : 1'b1;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   dcas_sequencer DUT (.clk(clk), .rst_b(rst_b), .cpu_clk(cpu_clk), .cpu_addr_strobe_b(as_b),
      .chip_select_b(cs_b), .read_not_write(rnw), .refresh_request_line(rfrq_b),
      .any_byte_strobe_b(byte_b), .hidden_refresh_disable_b(hrd_b), .wait_req_b(wait_b),
      .row_strobe_request_b(ras_b), .cycle_done_b(done_b), .access_during_refresh_b(flag_b),
      .transfer_acknowledge_b(ack_b), .transfer_acknowledge_oe(ack_oe),
      .controller_mode_select_b(mode_b), .delay_stage_one_b(s1_b),
      .delay_stage_two_b(s2_b), .delay_stage_three_b(s3_b));

   dcas_cpu_model cpu (.clk(clk), .cpu_clk(cpu_clk), .as_b(as_b), .cs_b(cs_b), .rnw(rnw),
      .rfrq_b(rfrq_b), .byte_b(byte_b), .wait_b(wait_b), .ack_w(ack_w), .ras_b(ras_b),
      .done_b(done_b), .flag_b(flag_b), .mode_b(mode_b));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // Reads with and without a wait state, then a write with one
   task automatic test_access;
      cpu.cycle(1'b1, 1'b1, 1'b0, 400, lat_n, seen);
      check({seen[2:1], lat_n >= 0}, 3'h7);
      check({done_b, ack_oe}, 2'h2);
      cpu.cycle(1'b1, 1'b1, 1'b1, 400, lat, seen);
      check(lat > lat_n, 1'b1);
      cpu.cycle(1'b1, 1'b0, 1'b1, 400, lat, seen);
      check({seen[2], lat >= 0}, 2'h3);
      $display("test access done");
   endtask : test_access

   // Foreign accesses with hidden refresh on, then off
   task automatic test_hidden;
      cpu.cycle(1'b0, 1'b1, 1'b0, 120, lat, seen);
      check({seen[2:1], lat < 0}, 3'h7);
      @(posedge clk);
      hrd_b <= 1'b0;
      cpu.cycle(1'b0, 1'b1, 1'b0, 120, lat, seen);
      check(seen[2], 1'b0);
      $display("test hidden done");
   endtask : test_hidden

   // Selected read arriving during a forced refresh from an idle bus
   task automatic test_forced;
      fork
         cpu.force_refresh(ok);
         begin
            repeat (30) @(posedge clk);
            cpu.cycle(1'b1, 1'b1, 1'b0, 400, lat, seen);
         end
      join
      check({ok, seen[0], lat > lat_n}, 3'h7);
      $display("test forced done");
   endtask : test_forced

   // Forced refresh inside a long foreign access
   task automatic test_long;
      fork
         cpu.cycle(1'b0, 1'b1, 1'b0, 300, lat, seen);
         begin
            repeat (100) @(posedge clk);
            cpu.force_refresh(ok);
         end
      join
      check({ok, seen[1]}, 2'h3);
      $display("test long done");
   endtask : test_long

   // Reset, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      hrd_b = 1'b1;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check({ras_b, done_b, flag_b, ack_oe, mode_b, s1_b, s2_b, s3_b}, 8'hEF);
      $display("test reset done");
      test_access;
      test_hidden;
      test_forced;
      test_long;
      give_verdict;
   end

   // Cuts a hang short
   initial begin
      #300000;
      mismatches++;
      give_verdict;
   end
endmodule : dcas_sequencer_test

`default_nettype wire
